// file: fpa_pkg.sv
// constants, states and helpers shared by the flash access sequencer files
// assumes a single 100 MHz clock and a cpu-style byte bus in front of the array
// Summary of operation
// - block array reads and fetches while busy
// - byte program and read, chip/4k sector erase
// - reads single transfer, commands multi-write sequences
// - sequences accepted only when enable field 0011b
// - ram loader mode holds watchdog disabled
// - serial mode boot path reaches flash via banks
// - busy reads invert the toggle status bit
// - first toggle read after start returns one
// - chip erase leaves every byte ffh
package fpa_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROG_TIME_NS = 40000;
	localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
	localparam int ERASE_TIME_MS = 30;
	localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000000 / CLK_PERIOD_NS;
	// ----------------------------------------------------------------
	// command codes and addresses
	// ----------------------------------------------------------------
	localparam logic [3:0] CMD_ENABLE = 4'h3;
	localparam logic [3:0] CMD_DISABLE = 4'hc;
	localparam logic [11:0] UNLOCK_A = 12'h555;
	localparam logic [11:0] UNLOCK_B = 12'haaa;
	localparam logic [7:0] KEY_A = 8'haa;
	localparam logic [7:0] KEY_B = 8'h55;
	localparam logic [7:0] OP_PROG = 8'ha0;
	localparam logic [7:0] OP_ERASE = 8'h80;
	localparam logic [7:0] OP_PROTECT = 8'ha5;
	localparam logic [7:0] OP_SECTOR = 8'h30;
	localparam logic [7:0] OP_CHIP = 8'h10;
	localparam logic [15:0] PROTECT_ADDR = 16'hff7f;
	localparam logic [7:0] PROTECT_DATA = 8'h00;
	localparam logic [7:0] ERASED = 8'hff;
	localparam int TOGGLE_BIT = 6;
	localparam int SECTOR_W = 12;
	localparam logic [2:0] STEP_LAST = 3'h5;
	// ----------------------------------------------------------------
	// sequencer states and command kinds
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FPA_IDLE = 2'b00,
		FPA_PROG = 2'b01,
		FPA_WALK = 2'b10,
		FPA_WAIT = 2'b11
	} fpa_state_e;
	typedef enum logic [1:0] {
		FPA_K_NONE = 2'b00,
		FPA_K_PROG = 2'b01,
		FPA_K_ERASE = 2'b10,
		FPA_K_PROT = 2'b11
	} fpa_kind_e;
	// low twelve address bits compared against an unlock address
	function automatic logic hit(input logic [15:0] a, input logic [11:0] u);
		hit = (a[11:0] == u);
	endfunction : hit
endpackage : fpa_pkg

// file: fpa_mem_if.sv
// carrier between the sequencer and its byte array
// assumes both ends share core_clk
`timescale 1ns/1ps
interface fpa_mem_if #(parameter int ADDR_W = 16) ();
	logic we; // one-cycle byte write
	logic [ADDR_W-1:0] waddr; // write address
	logic [7:0] wdata; // write byte
	logic [ADDR_W-1:0] raddr; // read address, sampled every edge
	logic [7:0] rdata; // registered read byte
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : fpa_mem_if

// file: fpa_array.sv
// byte-wide flash array model: one write port, one registered read port
// assumes the sequencer alone drives writes
`timescale 1ns/1ps
module fpa_array #(
	parameter int ADDR_W = 16
) (
	input wire logic core_clk,
	fpa_mem_if.mem port
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	// contents are not reset; a real array keeps its data through reset
	logic [7:0] cells [2**ADDR_W];
	// write and registered read
	always_ff @(posedge core_clk) begin
		if (port.we) begin
			cells[port.waddr] <= port.wdata;
		end
		port.rdata <= cells[port.raddr];
	end
endmodule : fpa_array

// file: fpa_top.sv
// flash program/erase sequencer: decodes unlock write sequences, runs the
// busy phase, blocks array reads with toggle status while busy
// assumes the cpu bus presents one-cycle read and write strobes
`timescale 1ns/1ps
module fpa_top #(
	parameter int ADDR_W = 16,
	parameter int ERASE_WAIT = fpa_pkg::ERASE_CYCLES,
	parameter int PROG_WAIT = fpa_pkg::PROG_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [7:0] cpu_wdata,
	input wire logic [3:0] command_enable_field,
	input wire logic bank_select,
	input wire logic serial_prom_mode,
	input wire logic ram_loader_mode,
	output logic [7:0] read_data,
	output logic read_valid,
	output logic access_blocked,
	output logic op_busy,
	output logic read_protect,
	output logic watchdog_hold
);
	import fpa_pkg::*;

	// elaboration check: the address map and both busy counters need these
	if (ADDR_W != 16 || ERASE_WAIT < 1 || PROG_WAIT < 1) begin : g_bad_params
		$error("fpa_top: unsupported parameters");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		fpa_state_e state; // sequencer phase
		fpa_kind_e kind; // command picked at third write
		logic [2:0] step; // unlock writes seen so far
		logic chip; // erase covers whole array
		logic [ADDR_W-1:0] ptr; // erase walk pointer
		logic [31:0] timer; // busy countdown
		logic toggle; // next toggle status value
		logic rd_pend; // array read in flight
		logic rd_stat; // that read is a status read
		logic rd_tog; // toggle value owed to that read, caught when it was taken
		logic fresh; // no busy read taken since the operation started
		logic [7:0] read_data;
		logic read_valid;
		logic access_blocked;
		logic read_protect;
		logic watchdog_hold;
	} fpa_state_s;

	fpa_state_s st;
	fpa_state_s next_st;
	fpa_mem_if #(.ADDR_W(ADDR_W)) mem ();
	logic [ADDR_W-1:0] phys; // mapped cpu address
	logic busy; // any operation running

	function automatic logic [15:0] map_addr(input logic [15:0] a, input logic s, input logic b);
		map_addr = s ? {b, a[14:0]} : a;
	endfunction : map_addr

	assign phys = map_addr(cpu_addr, serial_prom_mode, bank_select);
	assign busy = (st.state != FPA_IDLE);

	fpa_array #(.ADDR_W(ADDR_W)) u_array (
		.core_clk(core_clk),
		.port(mem)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		mem.we = 1'b0;
		mem.waddr = phys;
		mem.wdata = cpu_wdata;
		mem.raddr = phys;
		next_st.read_valid = 1'b0;
		next_st.watchdog_hold = ram_loader_mode;
		// read pipeline: request, array, output flop
		next_st.rd_pend = cpu_rd;
		next_st.rd_stat = busy;
		// the toggle flips on the take edge, so the owed value is caught before that
		next_st.rd_tog = st.toggle;
		if (st.rd_pend) begin
			next_st.read_valid = 1'b1;
			next_st.read_data = mem.rdata;
			if (st.rd_stat) begin
				next_st.read_data = 8'h00;
				next_st.read_data[TOGGLE_BIT] = st.rd_tog;
			end
		end
		// each busy read flips the bit
		if (cpu_rd && busy) begin
			next_st.toggle = ~st.toggle;
			next_st.fresh = 1'b0;
		end
		unique case (st.state)
			FPA_IDLE: begin
				if (cpu_wr && command_enable_field != CMD_ENABLE) begin
					next_st.step = 3'h0;
				end else if (cpu_wr) begin
					next_st.step = 3'h0;
					unique case (st.step)
						3'h0: if (hit(cpu_addr, UNLOCK_A) && cpu_wdata == KEY_A) begin
							next_st.step = 3'h1;
						end
						3'h1: if (hit(cpu_addr, UNLOCK_B) && cpu_wdata == KEY_B) begin
							next_st.step = 3'h2;
						end
						3'h2: if (hit(cpu_addr, UNLOCK_A)) begin
							next_st.step = 3'h3;
							if (cpu_wdata == OP_PROG) begin
								next_st.kind = FPA_K_PROG;
							end else if (cpu_wdata == OP_ERASE) begin
								next_st.kind = FPA_K_ERASE;
							end else if (cpu_wdata == OP_PROTECT) begin
								next_st.kind = FPA_K_PROT;
							end else begin
								next_st.step = 3'h0;
							end
						end
						3'h3: begin
							if (st.kind == FPA_K_PROG) begin
								mem.we = 1'b1;
								next_st.state = FPA_PROG;
								next_st.timer = PROG_WAIT;
							end else if (st.kind == FPA_K_PROT) begin
								if (cpu_addr == PROTECT_ADDR && cpu_wdata == PROTECT_DATA) begin
									next_st.read_protect = 1'b1;
									next_st.state = FPA_PROG;
									next_st.timer = PROG_WAIT;
								end
							end else if (hit(cpu_addr, UNLOCK_A) && cpu_wdata == KEY_A) begin
								next_st.step = 3'h4;
							end
						end
						3'h4: if (hit(cpu_addr, UNLOCK_B) && cpu_wdata == KEY_B) begin
							next_st.step = STEP_LAST;
						end
						3'h5: begin
							if (cpu_wdata == OP_SECTOR) begin
								next_st.chip = 1'b0;
								next_st.ptr = {phys[ADDR_W-1:SECTOR_W], {SECTOR_W{1'b0}}};
								next_st.state = FPA_WALK;
							end else if (cpu_wdata == OP_CHIP && hit(cpu_addr, UNLOCK_A)) begin
								next_st.chip = 1'b1;
								next_st.ptr = '0;
								next_st.read_protect = 1'b0;
								next_st.state = FPA_WALK;
							end
						end
						default: next_st.step = 3'h0;
					endcase
					if (next_st.state != FPA_IDLE) begin
						next_st.toggle = 1'b1;
						next_st.fresh = 1'b1;
						next_st.kind = FPA_K_NONE;
					end
				end
			end
			FPA_PROG, FPA_WAIT: begin
				// writes while busy are ignored
				next_st.timer = st.timer - 32'd1;
				if (st.timer <= 32'd1) begin
					next_st.state = FPA_IDLE;
				end
			end
			FPA_WALK: begin
				mem.we = 1'b1;
				mem.waddr = st.ptr;
				mem.wdata = ERASED;
				next_st.ptr = st.ptr + 1'b1;
				if ((st.chip && &st.ptr) || (!st.chip && &st.ptr[SECTOR_W-1:0])) begin
					next_st.state = FPA_WAIT;
					next_st.timer = ERASE_WAIT;
				end
			end
		endcase
		next_st.access_blocked = (next_st.state != FPA_IDLE);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// synchronous reset; read protection is volatile in this model
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign read_data = st.read_data;
	assign read_valid = st.read_valid;
	assign access_blocked = st.access_blocked;
	assign op_busy = st.access_blocked;
	assign read_protect = st.read_protect;
	assign watchdog_hold = st.watchdog_hold;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// busy reads return status only
	a_busy_read_status: assert property (@(posedge core_clk) disable iff (!reset_n)
		cpu_rd && busy |-> ##2 read_valid && (read_data & ~(8'h01 << TOGGLE_BIT)) == 8'h00)
		else $error("busy read leaked array data");
	a_toggle_flips: assert property (@(posedge core_clk) disable iff (!reset_n)
		cpu_rd && busy ##1 cpu_rd && busy
		|-> ##2 read_data[TOGGLE_BIT] != $past(read_data[TOGGLE_BIT]))
		else $error("toggle bit did not invert");
	// first read after start is one
	a_first_toggle: assert property (@(posedge core_clk) disable iff (!reset_n)
		cpu_rd && busy && st.fresh |-> ##2 read_valid && read_data[TOGGLE_BIT])
		else $error("first toggle read not one");
	a_disabled_ignored: assert property (@(posedge core_clk) disable iff (!reset_n)
		!busy && cpu_wr && command_enable_field != CMD_ENABLE |=> !busy && st.step == 3'h0)
		else $error("sequence advanced while disabled");
	a_enabled_unlock: assert property (@(posedge core_clk) disable iff (!reset_n)
		!busy && st.step == 3'h0 && cpu_wr && command_enable_field == CMD_ENABLE
		&& cpu_addr[11:0] == UNLOCK_A && cpu_wdata == KEY_A |=> st.step == 3'h1)
		else $error("enabled unlock write not taken");
	a_erase_ff: assert property (@(posedge core_clk) disable iff (!reset_n)
		st.state == FPA_WALK |-> mem.we && mem.wdata == ERASED)
		else $error("erase wrote non-erased value");
	a_one_byte: assert property (@(posedge core_clk) disable iff (!reset_n)
		st.state == FPA_IDLE ##1 st.state == FPA_PROG |-> !mem.we [*2])
		else $error("program wrote more than one byte");
	a_blocked_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
		$rose(busy) |-> access_blocked && op_busy)
		else $error("blocked flag missing during operation");
	a_wdt_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
		ram_loader_mode ##1 ram_loader_mode |-> watchdog_hold)
		else $error("watchdog not held in loader mode");
endmodule : fpa_top

// file: fpa_cpu_model.sv
// cpu model: the ram control program driving the sequencer's byte bus
// assumes read_valid is registered high at the first edge after the edge that
// takes a read, so it stands in the cycle that follows that first edge
`timescale 1ns/1ps
module fpa_cpu_model (
	input wire logic core_clk,
	output logic [15:0] cpu_addr,
	output logic cpu_wr,
	output logic cpu_rd,
	output logic [7:0] cpu_wdata,
	input wire logic [7:0] read_data,
	input wire logic read_valid
);
	logic [7:0] last_rd; // latest read byte, x when its slot was missed
	initial begin
		cpu_addr = 16'h0000;
		cpu_wr = 1'b0;
		cpu_rd = 1'b0;
		cpu_wdata = 8'h00;
	end
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		cpu_wr <= 1'b1;
		cpu_addr <= a;
		cpu_wdata <= d;
		@(posedge core_clk);
		cpu_wr <= 1'b0; // released lines flip so stale values never pass
		cpu_addr <= ~a;
		cpu_wdata <= ~d;
	endtask : wr
	// one read, data taken in its slot only
	task automatic rd(input logic [15:0] a);
		@(posedge core_clk);
		cpu_rd <= 1'b1;
		cpu_addr <= a;
		@(posedge core_clk);
		cpu_rd <= 1'b0;
		cpu_addr <= ~a;
		// one edge after the release the result stands for one cycle
		@(posedge core_clk);
		#1;
		last_rd = (read_valid === 1'b1) ? read_data : 8'hxx;
	endtask : rd
	task automatic poll(input logic [15:0] a, output logic done);
		logic [7:0] prev;
		done = 1'b0;
		// a chip erase walk lasts over 65k cycles at three cycles a read
		for (int i = 0; i < 25000 && !done; i++) begin
			rd(a);
			done = (i > 0) && (last_rd === prev);
			prev = last_rd;
		end
	endtask : poll
endmodule : fpa_cpu_model

// file: flash_program_erase_access_tb.sv
// self-checking bench for the flash program/erase sequencer
// assumes the cpu model makes all bus cycles; field and mode inputs set here
`timescale 1ns/1ps
module flash_program_erase_access_tb;
	import fpa_pkg::*;
	localparam int PW = 20; // short program busy, still long enough for two reads
	localparam int EW = 10; // short erase wait after the walk
	logic core_clk = 1'b0, reset_n = 1'b0;
	logic [3:0] command_enable_field = CMD_ENABLE;
	logic bank_select = 1'b0, serial_prom_mode = 1'b0, ram_loader_mode = 1'b0;
	logic [15:0] cpu_addr;
	logic [7:0] cpu_wdata, read_data;
	logic cpu_wr, cpu_rd, read_valid, access_blocked, op_busy, read_protect, watchdog_hold, ok;
	int err_total = 0, cmp_count = 0;
	// short busy counts keep a chip erase near 66k cycles
	fpa_top #(.ADDR_W(16), .ERASE_WAIT(EW), .PROG_WAIT(PW)) u_dut (
		.core_clk(core_clk), .reset_n(reset_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
		.cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .command_enable_field(command_enable_field),
		.bank_select(bank_select), .serial_prom_mode(serial_prom_mode),
		.ram_loader_mode(ram_loader_mode), .read_data(read_data), .read_valid(read_valid),
		.access_blocked(access_blocked), .op_busy(op_busy), .read_protect(read_protect),
		.watchdog_hold(watchdog_hold)
	);
	// far-side cpu
	fpa_cpu_model u_cpu (
		.core_clk(core_clk), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
		.cpu_wdata(cpu_wdata), .read_data(read_data), .read_valid(read_valid)
	);
	// free-running clock
	always #5 core_clk = ~core_clk;
	// compare and count, report a mismatch at once
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// verdict, the only end of the run
	task automatic finish_test();
		if (err_total == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : finish_test
	// unlock pair, opcode, a second unlock for erase, then the final write
	task automatic cmd(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d);
		u_cpu.wr({4'hf, UNLOCK_A}, KEY_A);
		u_cpu.wr({4'hf, UNLOCK_B}, KEY_B);
		u_cpu.wr({4'hf, UNLOCK_A}, op);
		if (op == OP_ERASE) begin
			u_cpu.wr({4'hf, UNLOCK_A}, KEY_A);
			u_cpu.wr({4'hf, UNLOCK_B}, KEY_B);
		end
		u_cpu.wr(a, d);
	endtask : cmd
	// busy phase: status instead of data, toggle starts at one, then poll out
	task automatic busy(input logic [15:0] a);
		u_cpu.rd(a);
		chk(u_cpu.last_rd, 8'h01 << TOGGLE_BIT);
		u_cpu.rd(a);
		chk(u_cpu.last_rd, 8'h00);
		chk(8'(op_busy), 8'h01);
		u_cpu.poll(a, ok);
		chk(8'(ok), 8'h01);
	endtask : busy
	task automatic prog(input logic [15:0] a, input logic [7:0] d);
		cmd(OP_PROG, a, d);
		busy(a);
	endtask : prog
	task automatic rchk(input logic [15:0] a, input logic [7:0] e);
		u_cpu.rd(a);
		chk(u_cpu.last_rd, e);
	endtask : rchk
	// protect, chip erase, sector erase bounds, rewrite only after erase
	task automatic t_array();
		cmd(OP_PROTECT, PROTECT_ADDR, PROTECT_DATA);
		busy(16'h1234);
		chk(8'(read_protect), 8'h01);
		cmd(OP_ERASE, {4'hf, UNLOCK_A}, OP_CHIP);
		busy(16'hf555);
		chk(8'(read_protect), 8'h00);
		rchk(16'hffff, ERASED);
		prog(16'h7abc, 8'h12);
		prog(16'h8000, 8'h34);
		cmd(OP_ERASE, 16'h7123, OP_SECTOR);
		busy(16'h7123);
		rchk(16'h7abc, ERASED);
		rchk(16'h8000, 8'h34);
		prog(16'h7abc, 8'ha9);
		rchk(16'h7abc, 8'ha9);
	endtask : t_array
	// serial bank mapping, loader watchdog hold, sequence with the field disabled
	task automatic t_modes();
		@(posedge core_clk);
		serial_prom_mode <= 1'b1;
		bank_select <= 1'b1;
		prog(16'h0010, 8'h9a);
		@(posedge core_clk);
		serial_prom_mode <= 1'b0;
		ram_loader_mode <= 1'b1;
		command_enable_field <= CMD_DISABLE;
		rchk(16'h8010, 8'h9a);
		chk(8'(watchdog_hold), 8'h01);
		cmd(OP_PROG, 16'h2000, 8'h5a);
		rchk(16'h2000, ERASED);
	endtask : t_modes
	// reset for two cycles, then the scenarios in software order
	initial begin
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		#1;
		chk(8'({access_blocked, op_busy, read_valid, read_protect}), 8'h00);
		t_array();
		t_modes();
		finish_test();
	end
	// watchdog: the scenarios need about 70k cycles, mostly the chip erase walk
	initial begin
		repeat (95000) @(posedge core_clk);
		err_total++;
		finish_test();
	end
endmodule : flash_program_erase_access_tb
